// ===== core/lcell_pkg.sv
// Constants for the logic cell data 3/4 select and gate 1 term select block
`default_nettype none
package lcell_pkg;
   // Bus geometry
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   // Candidate input count and select code width
   localparam int NUM_IN = 8;
   localparam int SEL_W = 3;
   localparam int CHAN_NUM = 4;
   // Register byte offsets
   localparam logic [ADDR_W-1:0] SEL34_OFFSET = 12'h000;
   localparam logic [ADDR_W-1:0] GATE1_OFFSET = 12'h004;
   localparam logic [ADDR_W-1:0] POL_OFFSET = 12'h008;
   // Field positions in the data 3/4 select register
   localparam int D4_LSB = 4;
   localparam int D3_LSB = 0;
   localparam logic [7:0] SEL34_IMPL_MASK = 8'h77;
   // Field positions in the gate 1 term select register
   localparam int G1_D4T_BIT = 7;
   localparam int G1_D4N_BIT = 6;
   localparam int G1_D3T_BIT = 5;
   localparam int G1_D3N_BIT = 4;
   localparam int G1_D2T_BIT = 3;
   localparam int G1_D2N_BIT = 2;
   localparam int G1_D1T_BIT = 1;
   localparam int G1_D1N_BIT = 0;
   // Field position in the polarity register
   localparam int POL_BIT = 0;
   // Reset values
   localparam logic [7:0] SEL34_RESET = 8'h00;
   localparam logic [7:0] GATE1_RESET = 8'h00;
   localparam logic POL_RESET = 1'b0;
   localparam logic [DATA_W-1:0] RDATA_RESET = 32'h0000_0000;
endpackage
`default_nettype wire

// ===== core/lcell_gate1.sv
// Logic cell data 3/4 input select, gate 1 term select and polarity, APB slave
// Operation
// - Bits 6..4 of data 3/4 select pick candidate input N for data channel 4.
// - Bits 2..0 of data 3/4 select pick candidate input N for data channel 3.
// - Bits 7 and 3 of data 3/4 select read zero, writes ignored.
// - Implemented bits of all three registers are read/write; kept until rewritten.
// - Gate 1 select bit 7 gates true channel 4, bit 6 inverted channel 4.
// - Gate 1 select bit 5 gates true channel 3, bit 4 inverted channel 3.
// - Gate 1 select bit 3 gates true channel 2, bit 2 inverted channel 2.
// - Gate 1 select bit 1 gates true channel 1, bit 0 inverted channel 1.
// - Polarity bit set inverts gate 1 output; clear passes it unchanged.
//
// Decided for this implementation: the register addresses and register access over APB.
`default_nettype none
module lcell_gate1 (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [lcell_pkg::ADDR_W-1:0] paddr,
   input wire logic [lcell_pkg::DATA_W-1:0] pwdata,
   output logic [lcell_pkg::DATA_W-1:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [lcell_pkg::NUM_IN-1:0] candidate_inputs,
   input wire logic data_channel_1,
   input wire logic data_channel_2,
   output logic data_channel_3,
   output logic data_channel_4,
   output logic gate_one_out
);
   import lcell_pkg::*;

   typedef struct packed {
      logic [7:0] sel34_reg;
      logic [7:0] gate1_reg;
      logic pol_reg;
      logic [NUM_IN-1:0] in_meta_reg;
      logic [NUM_IN-1:0] in_sync_reg;
      logic d3_reg;
      logic d4_reg;
      logic g1_reg;
      logic [DATA_W-1:0] prdata_reg;
      logic pready_reg;
      logic pslverr_reg;
   } state_t;

   localparam state_t STATE_RESET = '{
      sel34_reg: SEL34_RESET,
      gate1_reg: GATE1_RESET,
      pol_reg: POL_RESET,
      in_meta_reg: '0,
      in_sync_reg: '0,
      d3_reg: 1'b0,
      d4_reg: 1'b0,
      g1_reg: 1'b0,
      prdata_reg: RDATA_RESET,
      pready_reg: 1'b0,
      pslverr_reg: 1'b0
   };

   state_t st_reg;
   state_t st_next;

   logic [CHAN_NUM-1:0] chan;
   logic [CHAN_NUM-1:0] term;
   logic access_first;
   logic access_done;
   logic wr_commit;
   logic hit_sel34;
   logic hit_gate1;
   logic hit_pol;

   // Channel order matches the term select layout: index 0 is data channel 1
   assign chan = {st_reg.d4_reg, st_reg.d3_reg, data_channel_2, data_channel_1};

   // Each channel contributes its true and inverted term when enabled
   for (genvar i = 0; i < CHAN_NUM; i++) begin : g_term
      assign term[i] = (st_reg.gate1_reg[2*i+1] & chan[i])
                     | (st_reg.gate1_reg[2*i] & ~chan[i]);
   end

   assign hit_sel34 = (paddr == SEL34_OFFSET);
   assign hit_gate1 = (paddr == GATE1_OFFSET);
   assign hit_pol = (paddr == POL_OFFSET);
   // One wait state: pready rises in the second access cycle
   assign access_first = psel && penable && !st_reg.pready_reg;
   assign access_done = psel && penable && st_reg.pready_reg;
   assign wr_commit = access_done && pwrite && !st_reg.pslverr_reg;

   always_comb begin
      st_next = st_reg;
      // Two-stage synchroniser for asynchronous candidate inputs
      st_next.in_meta_reg = candidate_inputs;
      st_next.in_sync_reg = st_reg.in_meta_reg;
      st_next.d4_reg = st_reg.in_sync_reg[st_reg.sel34_reg[D4_LSB +: SEL_W]];
      st_next.d3_reg = st_reg.in_sync_reg[st_reg.sel34_reg[D3_LSB +: SEL_W]];
      st_next.g1_reg = st_reg.pol_reg ^ (|term);

      st_next.pready_reg = access_first;
      if (access_first) begin
         st_next.pslverr_reg = !(hit_sel34 || hit_gate1 || hit_pol);
         if (hit_sel34) begin
            st_next.prdata_reg = {24'h00_0000, st_reg.sel34_reg & SEL34_IMPL_MASK};
         end else if (hit_gate1) begin
            st_next.prdata_reg = {24'h00_0000, st_reg.gate1_reg};
         end else if (hit_pol) begin
            st_next.prdata_reg = {31'h0000_0000, st_reg.pol_reg};
         end else begin
            st_next.prdata_reg = RDATA_RESET;
         end
      end else if (access_done) begin
         st_next.pslverr_reg = 1'b0;
      end

      // Writes land only at the edge where the master samples pready high
      if (wr_commit) begin
         if (hit_sel34) begin
            st_next.sel34_reg = pwdata[7:0] & SEL34_IMPL_MASK;
         end
         if (hit_gate1) begin
            st_next.gate1_reg = pwdata[7:0];
         end
         if (hit_pol) begin
            st_next.pol_reg = pwdata[POL_BIT];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_reg <= STATE_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign prdata = st_reg.prdata_reg;
   assign pready = st_reg.pready_reg;
   assign pslverr = st_reg.pslverr_reg;
   assign data_channel_3 = st_reg.d3_reg;
   assign data_channel_4 = st_reg.d4_reg;
   assign gate_one_out = st_reg.g1_reg;

   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   // Channel 4 follows the selected synchronised input one edge later
   a_d4_route_sel: assert property (
      st_reg.d4_reg == $past(st_reg.in_sync_reg[st_reg.sel34_reg[D4_LSB +: SEL_W]], 1))
      else $error("data channel 4 does not follow selected input");

   // Channel 3 follows the selected synchronised input one edge later
   a_d3_route_sel: assert property (
      st_reg.d3_reg == $past(st_reg.in_sync_reg[st_reg.sel34_reg[D3_LSB +: SEL_W]], 1))
      else $error("data channel 3 does not follow selected input");

   // A pin change reaches channel 4 three edges later when code 0 is held
   a_pin_to_d4: assert property (
      (st_reg.sel34_reg[D4_LSB +: SEL_W] == 3'h0)[*4]
      |-> st_reg.d4_reg == $past(candidate_inputs[0], 3))
      else $error("pin to channel 4 latency wrong");

   // Unimplemented select bits read back as zero
   a_rsvd_read_zero: assert property (
      (access_first && hit_sel34)
      |=> pready && prdata[7] == 1'b0 && prdata[3] == 1'b0 && prdata[31:8] == 24'h00_0000)
      else $error("unimplemented select bits not zero");

   // A committed gate select write is stored unchanged
   a_gate_write_back: assert property (
      (access_done && pwrite && hit_gate1)
      |=> st_reg.gate1_reg == $past(pwdata[7:0], 1))
      else $error("gate 1 select write not stored");

   // Without a committed write the gate 1 and select registers hold their value
   a_regs_hold: assert property (
      !(access_done && pwrite) |=> $stable(st_reg.gate1_reg) && $stable(st_reg.sel34_reg))
      else $error("register changed without a write");

   // Access phase lasts exactly two cycles
   a_one_wait: assert property (
      (psel && penable && !pready) |=> pready ##1 !pready)
      else $error("pready timing wrong");

   // Enabled true channel 4 drives gate 1 high with no inversion
   a_d4_true_term: assert property (
      (!st_reg.pol_reg && st_reg.gate1_reg[G1_D4T_BIT] && st_reg.d4_reg) |=> gate_one_out)
      else $error("true channel 4 term not gated");

   // Enabled inverted channel 3 drives gate 1 high when channel 3 is low
   a_d3_inv_term: assert property (
      (!st_reg.pol_reg && st_reg.gate1_reg[G1_D3N_BIT] && !st_reg.d3_reg) |=> gate_one_out)
      else $error("inverted channel 3 term not gated");

   // Enabled true channel 2 drives gate 1 high
   a_d2_true_term: assert property (
      (!st_reg.pol_reg && st_reg.gate1_reg[G1_D2T_BIT] && data_channel_2) |=> gate_one_out)
      else $error("true channel 2 term not gated");

   // Enabled inverted channel 1 drives gate 1 high when channel 1 is low
   a_d1_inv_term: assert property (
      (!st_reg.pol_reg && st_reg.gate1_reg[G1_D1N_BIT] && !data_channel_1) |=> gate_one_out)
      else $error("inverted channel 1 term not gated");

   // With no terms and inversion set, gate 1 reads one
   a_pol_invert: assert property (
      (st_reg.pol_reg && st_reg.gate1_reg == 8'h00) |=> gate_one_out)
      else $error("polarity inversion missing");

   // With no terms and no inversion, gate 1 reads zero
   a_empty_zero: assert property (
      (!st_reg.pol_reg && st_reg.gate1_reg == 8'h00) |=> !gate_one_out)
      else $error("empty gate not zero");

   // Unmapped accesses answer with an error
   a_unmapped_err: assert property (
      (access_first && !(hit_sel34 || hit_gate1 || hit_pol)) |=> pready && pslverr)
      else $error("unmapped access without error");

   // An error response only ever comes with pready
   a_err_with_ready: assert property (
      pslverr |-> pready)
      else $error("error flag without ready");

   // pready only answers an access phase seen one edge earlier
   a_ready_after_access: assert property (
      pready |-> $past(psel, 1) && $past(penable, 1))
      else $error("ready without access phase");

   // A pin change reaches channel 3 three edges later when code 0 is held
   a_pin_to_d3: assert property (
      (st_reg.sel34_reg[D3_LSB +: SEL_W] == 3'h0)[*4]
      |-> st_reg.d3_reg == $past(candidate_inputs[0], 3))
      else $error("pin to channel 3 latency wrong");

   // A committed select write keeps both codes and drops bits 7 and 3
   a_sel34_store: assert property (
      (access_done && pwrite && hit_sel34)
      |=> st_reg.sel34_reg[6:4] == $past(pwdata[6:4], 1)
      && st_reg.sel34_reg[2:0] == $past(pwdata[2:0], 1)
      && !st_reg.sel34_reg[7] && !st_reg.sel34_reg[3])
      else $error("select write not stored as expected");

   // A gate select read returns the stored byte in the low bits
   a_gate_read_back: assert property (
      (access_first && hit_gate1)
      |=> prdata == {24'h00_0000, $past(st_reg.gate1_reg, 1)})
      else $error("gate 1 select read wrong");

   // A committed polarity write lands in the inversion bit
   a_pol_store: assert property (
      (access_done && pwrite && hit_pol)
      |=> st_reg.pol_reg == $past(pwdata[POL_BIT], 1))
      else $error("polarity write not stored");

   // Enabled inverted channel 4 drives gate 1 high when channel 4 is low
   a_d4_inv_term: assert property (
      (!st_reg.pol_reg && st_reg.gate1_reg[G1_D4N_BIT] && !st_reg.d4_reg) |=> gate_one_out)
      else $error("inverted channel 4 term not gated");

   // Enabled true channel 3 drives gate 1 high
   a_d3_true_term: assert property (
      (!st_reg.pol_reg && st_reg.gate1_reg[G1_D3T_BIT] && st_reg.d3_reg) |=> gate_one_out)
      else $error("true channel 3 term not gated");

   // Enabled inverted channel 2 drives gate 1 high when channel 2 is low
   a_d2_inv_term: assert property (
      (!st_reg.pol_reg && st_reg.gate1_reg[G1_D2N_BIT] && !data_channel_2) |=> gate_one_out)
      else $error("inverted channel 2 term not gated");

   // Enabled true channel 1 drives gate 1 high
   a_d1_true_term: assert property (
      (!st_reg.pol_reg && st_reg.gate1_reg[G1_D1T_BIT] && data_channel_1) |=> gate_one_out)
      else $error("true channel 1 term not gated");

   // Only the true channel 4 term enabled, channel 4 low: gate 1 stays low
   a_d4_excluded: assert property (
      (!st_reg.pol_reg && st_reg.gate1_reg == 8'h80 && !st_reg.d4_reg) |=> !gate_one_out)
      else $error("channel 4 term gated when off");

   // Only the inverted channel 3 term enabled, channel 3 high: gate 1 stays low
   a_d3_excluded: assert property (
      (!st_reg.pol_reg && st_reg.gate1_reg == 8'h10 && st_reg.d3_reg) |=> !gate_one_out)
      else $error("channel 3 term gated when off");

   // Only the true channel 2 term enabled, channel 2 low: gate 1 stays low
   a_d2_excluded: assert property (
      (!st_reg.pol_reg && st_reg.gate1_reg == 8'h08 && !data_channel_2) |=> !gate_one_out)
      else $error("channel 2 term gated when off");

   // Only the inverted channel 1 term enabled, channel 1 high: gate 1 stays low
   a_d1_excluded: assert property (
      (!st_reg.pol_reg && st_reg.gate1_reg == 8'h01 && data_channel_1) |=> !gate_one_out)
      else $error("channel 1 term gated when off");

   // Inversion turns an active true channel 4 term into a low output
   a_pol_true_term: assert property (
      (st_reg.pol_reg && st_reg.gate1_reg[G1_D4T_BIT] && st_reg.d4_reg) |=> !gate_one_out)
      else $error("inversion of active term missing");

   // Main scenarios
   c_unmapped_err: cover property (pready && pslverr);
   c_sel34_write: cover property (access_done && pwrite && hit_sel34);
   c_gate1_read: cover property (access_done && !pwrite && hit_gate1);
   c_gate_toggle: cover property (!gate_one_out ##1 gate_one_out ##1 !gate_one_out);
   c_inverted_out: cover property (st_reg.pol_reg && gate_one_out);
endmodule
`default_nettype wire

// ===== verif/input_source.sv
// Source model for the candidate inputs and data channels 1 and 2
`default_nettype none
module input_source (
   input wire logic pclk,
   input wire logic [9:0] stim,
   output logic [7:0] candidate_inputs,
   output logic data_channel_1,
   output logic data_channel_2
);
   timeunit 1ns;
   timeprecision 1ps;
   // On-chip sources change once per clock, just after the edge
   always_ff @(posedge pclk) begin
      {data_channel_2, data_channel_1, candidate_inputs} <= stim;
   end
endmodule
`default_nettype wire

// ===== verif/testbench.sv
// Self-checking bench for the data 3/4 select and gate 1 term select block
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import lcell_pkg::*;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, e;
   logic [ADDR_W-1:0] paddr = '0;
   logic [DATA_W-1:0] pwdata = '0, prdata, rd;
   logic [9:0] stim = '0;
   logic [7:0] cin;
   logic d1, d2, d3, d4, g1;
   int miscompares = 0, checked = 0, m_sel = 0, m_gate = 0, m_pol = 0, s, g;
   int unsigned seed = 27267;
   always #2.5 pclk = ~pclk;
   input_source src_u (.pclk(pclk), .stim(stim), .candidate_inputs(cin),
      .data_channel_1(d1), .data_channel_2(d2));
   lcell_gate1 dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .candidate_inputs(cin), .data_channel_1(d1),
      .data_channel_2(d2), .data_channel_3(d3), .data_channel_4(d4), .gate_one_out(g1));
   function automatic int unsigned xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp, input string m);
      checked++;
      if (got !== exp) begin
         miscompares++;
         $display("mismatch at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1);
      rd = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      check(n, 2, "ready latency");
   endtask
   function automatic logic [31:0] expect_rd(input logic [11:0] a);
      case (a)
         SEL34_OFFSET: return m_sel;
         GATE1_OFFSET: return m_gate;
         POL_OFFSET: return m_pol;
         default: return 0;
      endcase
   endfunction
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1, a, d);
      if (a == SEL34_OFFSET) m_sel = d & 32'h77;
      if (a == GATE1_OFFSET) m_gate = d & 32'hFF;
      if (a == POL_OFFSET) m_pol = d & 32'h1;
      check(e, expect_rd(a) === 0 && a > 12'h008 || a[1:0] != 0, "write error flag");
   endtask
   task automatic rd_chk(input logic [11:0] a);
      apb(0, a, 0);
      check(rd, expect_rd(a), "read back");
      check(e, a > 12'h008 || a[1:0] != 0, "read error flag");
   endtask
   // Settle the sources, then compare channels and gate against the model
   task automatic out_chk();
      logic c3, c4, c1, c2, gv;
      @(posedge pclk);
      stim <= 10'(xs());
      repeat (8) @(posedge pclk);
      c3 = stim[m_sel & 7];
      c4 = stim[(m_sel >> 4) & 7];
      c1 = stim[8];
      c2 = stim[9];
      gv = (m_gate[7] & c4) | (m_gate[6] & ~c4) | (m_gate[5] & c3) | (m_gate[4] & ~c3)
         | (m_gate[3] & c2) | (m_gate[2] & ~c2) | (m_gate[1] & c1) | (m_gate[0] & ~c1);
      check({d4, d3, g1}, {c4, c3, gv ^ m_pol[0]}, "channels and gate");
   endtask
   task automatic results();
      $display("comparisons %0d, mismatches %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      #40000;
      miscompares++;
      results();
   end
   initial begin
      repeat (3) @(posedge pclk);
      presetn <= 1;
      for (int a = 0; a < 16; a += 2) rd_chk(12'(a));
      wr(SEL34_OFFSET, 32'hFFFF_FFFF);
      rd_chk(SEL34_OFFSET);
      wr(12'h00C, 32'h0000_00FF);
      wr(GATE1_OFFSET, 32'h0000_00A5);
      rd_chk(GATE1_OFFSET);
      $display("register test done");
      for (int k = 0; k < 8; k++) begin
         wr(SEL34_OFFSET, (k << 4) | (k ^ 7));
         out_chk();
      end
      $display("select test done");
      for (int b = 0; b < 9; b++) begin
         wr(GATE1_OFFSET, (1 << b) & 32'hFF);
         wr(POL_OFFSET, xs());
         out_chk();
      end
      $display("term test done");
      for (int i = 0; i < 40; i++) begin
         s = xs();
         g = xs();
         wr(SEL34_OFFSET, s);
         wr(GATE1_OFFSET, g);
         wr(POL_OFFSET, xs());
         out_chk();
         rd_chk(SEL34_OFFSET);
      end
      $display("random test done");
      results();
   end
endmodule
`default_nettype wire
